/* logic/ext_gate_gen.sv */
/*
 * External trigger gate generator: AHB-Lite register slave, trigger source
 * selection, edge and level gating, gate counting.
 * Assumes trigger pins are asynchronous TTL levels and replay_underrun is a
 * one-cycle pulse on hclk from the replay engine.
 */
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "trig_gate_map.svh"

module ext_gate_gen (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic trig_main_pin,
   input wire logic extra_in0_pin,
   input wire logic extra_in1_pin,
   input wire logic extra_io_fitted,
   input wire logic replay_underrun,
   output logic gate_open,
   output logic replay_done
);

   // ***************************************************************
   // declarations
   // ***************************************************************
   logic [31:0] src_mask_q;
   logic [31:0] mode_q;
   logic [31:0] gate_count_q;
   logic wr_pend_q;
   logic [`TG_IDX_W-1:0] wr_idx_q;
   logic wr_ok_q;
   logic addr_phase;
   logic addr_mapped;
   logic [`TG_IDX_W-1:0] addr_idx;
   logic [31:0] rd_mux;
   logic wr_now;
   logic start_req;
   logic stop_req;
   logic main_lvl;
   logic x0_lvl;
   logic x1_lvl;
   logic xio_lvl;
   logic trig_now;
   logic trig_prev_q;
   logic rise;
   logic fall;
   trig_gate_pkg::gate_mode_t mode;
   trig_gate_pkg::run_state_t state_q;
   trig_gate_pkg::run_state_t state_d;
   logic open_cond;
   logic close_cond;
   logic gate_closed;
   logic last_gate;
   logic [31:0] gates_done;
   logic [31:0] status_word;

   // ***************************************************************
   // pin synchronisers
   // ***************************************************************
   pin_sync u_sync_main (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin(trig_main_pin),
      .level(main_lvl)
   );

   pin_sync u_sync_x0 (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin(extra_in0_pin),
      .level(x0_lvl)
   );

   pin_sync u_sync_x1 (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin(extra_in1_pin),
      .level(x1_lvl)
   );

   pin_sync u_sync_xio (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin(extra_io_fitted),
      .level(xio_lvl)
   );

   // ***************************************************************
   // ahb address phase decode
   // ***************************************************************
   assign addr_phase = hsel && hready && htrans[1];
   assign addr_idx = haddr[`TG_IDX_W+1:2];
   assign addr_mapped = (haddr[31:`TG_IDX_W+2] == '0) && (haddr[1:0] == 2'h0) &&
                        ((addr_idx == `TG_IDX_SRC_MASK) || (addr_idx == `TG_IDX_MODE) ||
                         (addr_idx == `TG_IDX_CTRL) || (addr_idx == `TG_IDX_GATE_COUNT) ||
                         (addr_idx == `TG_IDX_STATUS) || (addr_idx == `TG_IDX_GATES_DONE));

   // held write address for the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_idx_q <= '0;
         wr_ok_q <= 1'b0;
      end else if (hready) begin
         wr_pend_q <= addr_phase && hwrite;
         wr_idx_q <= addr_idx;
         wr_ok_q <= addr_mapped && (hsize == 3'h2);
      end
   end

   assign wr_now = wr_pend_q && wr_ok_q;

   // zero wait states, always okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ***************************************************************
   // read path, loaded at the address phase
   // ***************************************************************
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (addr_mapped) begin
         case (addr_idx)
            `TG_IDX_SRC_MASK: rd_mux = src_mask_q;
            `TG_IDX_MODE: rd_mux = mode_q;
            `TG_IDX_GATE_COUNT: rd_mux = gate_count_q;
            `TG_IDX_STATUS: rd_mux = status_word;
            `TG_IDX_GATES_DONE: rd_mux = gates_done;
            default: rd_mux = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         hrdata <= rd_mux;
      end
   end

   // ***************************************************************
   // software registers
   // ***************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         src_mask_q <= `TG_SRC_MASK_RST;
      end else if (wr_now && (wr_idx_q == `TG_IDX_SRC_MASK)) begin
         src_mask_q <= hwdata;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_q <= `TG_MODE_RST;
      end else if (wr_now && (wr_idx_q == `TG_IDX_MODE)) begin
         mode_q <= hwdata;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gate_count_q <= `TG_GATE_COUNT_RST;
      end else if (wr_now && (wr_idx_q == `TG_IDX_GATE_COUNT)) begin
         gate_count_q <= hwdata;
      end
   end

   // control strobes act in the data phase cycle
   assign start_req = wr_now && (wr_idx_q == `TG_IDX_CTRL) && hwdata[`TG_CTRL_START_BIT];
   assign stop_req = wr_now && (wr_idx_q == `TG_IDX_CTRL) && hwdata[`TG_CTRL_STOP_BIT];

   // ***************************************************************
   // trigger source or and edge detection
   // ***************************************************************
   assign trig_now = (src_mask_q[`TG_MASK_MAIN_BIT] && main_lvl) ||
                     (src_mask_q[`TG_MASK_X0_BIT] && xio_lvl && x0_lvl) ||
                     (src_mask_q[`TG_MASK_X1_BIT] && xio_lvl && x1_lvl);

   // previous sample tracks always, so a level at start gives no edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trig_prev_q <= 1'b0;
      end else begin
         trig_prev_q <= trig_now;
      end
   end

   assign rise = trig_now && !trig_prev_q;
   assign fall = !trig_now && trig_prev_q;

   // ***************************************************************
   // mode decode
   // ***************************************************************
   always_comb begin
      case (mode_q)
         `TG_MODE_RISE: mode = trig_gate_pkg::MODE_RISE;
         `TG_MODE_FALL: mode = trig_gate_pkg::MODE_FALL;
         `TG_MODE_HIGH: mode = trig_gate_pkg::MODE_HIGH;
         `TG_MODE_LOW: mode = trig_gate_pkg::MODE_LOW;
         `TG_MODE_RISE2: mode = trig_gate_pkg::MODE_RISE2;
         `TG_MODE_FALL2: mode = trig_gate_pkg::MODE_FALL2;
         default: mode = trig_gate_pkg::MODE_NONE;
      endcase
   end

   // open and close conditions per mode
   always_comb begin
      open_cond = 1'b0;
      close_cond = 1'b0;
      case (mode)
         trig_gate_pkg::MODE_RISE: begin
            open_cond = rise;
            close_cond = fall;
         end
         trig_gate_pkg::MODE_HIGH: begin
            open_cond = trig_now;
            close_cond = !trig_now;
         end
         trig_gate_pkg::MODE_RISE2: begin
            open_cond = rise;
            close_cond = rise;
         end
         trig_gate_pkg::MODE_FALL: begin
            open_cond = fall;
            close_cond = rise;
         end
         trig_gate_pkg::MODE_LOW: begin
            open_cond = !trig_now;
            close_cond = trig_now;
         end
         trig_gate_pkg::MODE_FALL2: begin
            open_cond = fall;
            close_cond = fall;
         end
         default: begin
            open_cond = 1'b0;
            close_cond = 1'b0;
         end
      endcase
   end

   // ***************************************************************
   // gating sequence
   // ***************************************************************
   assign gate_closed = (state_q == trig_gate_pkg::ST_OPEN) && close_cond && !stop_req && !replay_underrun;

   always_comb begin
      state_d = state_q;
      case (state_q)
         trig_gate_pkg::ST_IDLE: begin
            if (start_req) begin
               state_d = trig_gate_pkg::ST_WAIT_OPEN;
            end
         end
         trig_gate_pkg::ST_WAIT_OPEN: begin
            if (stop_req || replay_underrun) begin
               state_d = trig_gate_pkg::ST_IDLE;
            end else if (open_cond) begin
               state_d = trig_gate_pkg::ST_OPEN;
            end
         end
         trig_gate_pkg::ST_OPEN: begin
            if (stop_req || replay_underrun) begin
               state_d = trig_gate_pkg::ST_IDLE;
            end else if (close_cond) begin
               state_d = last_gate ? trig_gate_pkg::ST_DONE : trig_gate_pkg::ST_WAIT_OPEN;
            end
         end
         trig_gate_pkg::ST_DONE: begin
            if (start_req) begin
               state_d = trig_gate_pkg::ST_WAIT_OPEN;
            end else if (stop_req) begin
               state_d = trig_gate_pkg::ST_IDLE;
            end
         end
         default: state_d = trig_gate_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= trig_gate_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // outputs straight from flops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gate_open <= 1'b0;
         replay_done <= 1'b0;
      end else begin
         gate_open <= (state_d == trig_gate_pkg::ST_OPEN);
         replay_done <= (state_d == trig_gate_pkg::ST_DONE);
      end
   end

   // ***************************************************************
   // gate counting
   // ***************************************************************
   gate_counter u_gate_counter (
      .hclk(hclk),
      .hresetn(hresetn),
      .clear(start_req && ((state_q == trig_gate_pkg::ST_IDLE) || (state_q == trig_gate_pkg::ST_DONE))),
      .gate_closed(gate_closed),
      .target(gate_count_q),
      .count(gates_done),
      .last(last_gate)
   );

   // ***************************************************************
   // status word
   // ***************************************************************
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`TG_STAT_GATE_BIT] = (state_q == trig_gate_pkg::ST_OPEN);
      status_word[`TG_STAT_ARMED_BIT] = (state_q == trig_gate_pkg::ST_WAIT_OPEN) ||
                                        (state_q == trig_gate_pkg::ST_OPEN);
      status_word[`TG_STAT_DONE_BIT] = (state_q == trig_gate_pkg::ST_DONE);
      status_word[`TG_STAT_LEVEL_BIT] = trig_now;
      status_word[`TG_STAT_XIO_BIT] = xio_lvl;
   end

endmodule : ext_gate_gen

/* logic/gate_counter.sv */
/*
 * Counts closed gates and flags the gate whose closing reaches the programmed number.
 * Assumes a target of zero means no limit; clear restarts the count.
 */
`timescale 1ns/1ps

module gate_counter (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clear,
   input wire logic gate_closed,
   input wire logic [31:0] target,
   output logic [31:0] count,
   output logic last
);

   // ***************************************************************
   // count of completed gates
   // ***************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count <= 32'h0000_0000;
      end else if (clear) begin
         count <= 32'h0000_0000;
      end else if (gate_closed) begin
         count <= count + 32'h0000_0001;
      end
   end

   // closing gate is the final one
   assign last = (target != 32'h0000_0000) && (count + 32'h0000_0001 == target);

endmodule : gate_counter

/* logic/pin_sync.sv */
/*
 * Two-stage synchroniser for one asynchronous pin.
 * Assumes the pin is a slow TTL level; only the second stage is used downstream.
 */
`timescale 1ns/1ps

module pin_sync (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic pin,
   output logic level
);

   logic meta_q;

   // ***************************************************************
   // two flops, first one read only by the second
   // ***************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_q <= 1'b0;
         level <= 1'b0;
      end else begin
         meta_q <= pin;
         level <= meta_q;
      end
   end

endmodule : pin_sync

/* logic/trig_gate_map.svh */
/*
 * Register indices, field positions, mode codes and reset values of the
 * external trigger gate generator.
 * Assumes a 32-bit AHB-Lite bus: a register at index N sits at byte address 4*N.
 */
`ifndef TRIG_GATE_MAP_SVH
`define TRIG_GATE_MAP_SVH

// ***************************************************************
// register indices (byte address = 4 * index)
// ***************************************************************
`define TG_IDX_SRC_MASK 16'h9DDA
`define TG_IDX_MODE 16'h9E3E
`define TG_IDX_CTRL 16'h9E40
`define TG_IDX_GATE_COUNT 16'h9E41
`define TG_IDX_STATUS 16'h9E42
`define TG_IDX_GATES_DONE 16'h9E43
`define TG_IDX_W 16

// ***************************************************************
// source-enable mask fields
// ***************************************************************
`define TG_MASK_MAIN_BIT 1
`define TG_MASK_X0_BIT 8
`define TG_MASK_X1_BIT 9

// ***************************************************************
// gate mode codes
// ***************************************************************
`define TG_MODE_RISE 32'h0000_0001
`define TG_MODE_FALL 32'h0000_0002
`define TG_MODE_HIGH 32'h0000_0008
`define TG_MODE_LOW 32'h0000_0010
`define TG_MODE_RISE2 32'h0080_0001
`define TG_MODE_FALL2 32'h0080_0002

// ***************************************************************
// control and status fields
// ***************************************************************
`define TG_CTRL_START_BIT 0
`define TG_CTRL_STOP_BIT 1
`define TG_STAT_GATE_BIT 0
`define TG_STAT_ARMED_BIT 1
`define TG_STAT_DONE_BIT 2
`define TG_STAT_LEVEL_BIT 3
`define TG_STAT_XIO_BIT 4

// ***************************************************************
// reset values
// ***************************************************************
`define TG_SRC_MASK_RST 32'h0000_0000
`define TG_MODE_RST 32'h0000_0000
`define TG_GATE_COUNT_RST 32'h0000_0000

`endif

/* logic/trig_gate_pkg.sv */
/*
 * Types shared by the external trigger gate generator.
 * Assumes trig_gate_map.svh supplies the numeric constants.
 */
package trig_gate_pkg;

   // decoded gate behaviour
   typedef enum logic [2:0] {
      MODE_NONE,
      MODE_RISE,
      MODE_FALL,
      MODE_HIGH,
      MODE_LOW,
      MODE_RISE2,
      MODE_FALL2
   } gate_mode_t;

   // replay gating sequence
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT_OPEN,
      ST_OPEN,
      ST_DONE
   } run_state_t;

endpackage : trig_gate_pkg

/* tb/ext_gate_gen_properties.sv */
/*
 * Port checker of ext_gate_gen, bound into every instance.
 * Assumes one master, hready tied to hreadyout, register writes as whole words.
 */
`timescale 1ns/1ps
`include "trig_gate_map.svh"

module ext_gate_gen_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic trig_main_pin,
   input wire logic extra_in0_pin,
   input wire logic extra_in1_pin,
   input wire logic extra_io_fitted,
   input wire logic gate_open,
   input wire logic replay_done
);
   localparam logic [31:0] A_MASK = `TG_IDX_SRC_MASK * 4;
   localparam logic [31:0] A_MODE = `TG_IDX_MODE * 4;
   logic [31:0] mask_q, mode_q, wa_q;
   logic wv_q, rd_mode_q, rd_mask_q, take, comb, up_m, dn_m;
   logic [3:0] hi_q, lo_q;

   assign take = hsel & hready & htrans[1];
   assign comb = trig_main_pin & mask_q[1] | extra_io_fitted & (extra_in0_pin & mask_q[8] | extra_in1_pin & mask_q[9]);
   assign up_m = mode_q == `TG_MODE_RISE || mode_q == `TG_MODE_RISE2;
   assign dn_m = mode_q == `TG_MODE_FALL || mode_q == `TG_MODE_FALL2;

   // ***************************************************************
   // shadow of mask and mode
   // ***************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wv_q <= 1'b0;
         wa_q <= 32'h0000_0000;
         rd_mode_q <= 1'b0;
         rd_mask_q <= 1'b0;
         mask_q <= 32'h0000_0000;
         mode_q <= 32'h0000_0000;
      end else begin
         wv_q <= take & hwrite & (hsize == 3'h2);
         wa_q <= haddr;
         rd_mode_q <= take & !hwrite & (haddr == A_MODE);
         rd_mask_q <= take & !hwrite & (haddr == A_MASK);
         if (wv_q && wa_q == A_MASK) begin
            mask_q <= hwdata;
         end
         if (wv_q && wa_q == A_MODE) begin
            mode_q <= hwdata;
         end
      end
   end

   // cycles the combined trigger has stood high or low
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hi_q <= 4'h0;
         lo_q <= 4'h0;
      end else begin
         hi_q <= !comb ? 4'h0 : (hi_q == 4'hF ? hi_q : hi_q + 4'h1);
         lo_q <= comb ? 4'h0 : (lo_q == 4'hF ? lo_q : lo_q + 4'h1);
      end
   end

   // ***************************************************************
   // properties
   // ***************************************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not zero-wait okay");
   a_mode_readback: assert property (rd_mode_q |-> hrdata == mode_q)
      else $error("mode readback differs");
   a_mask_readback: assert property (rd_mask_q |-> hrdata == mask_q)
      else $error("mask readback differs");
   a_rise_open: assert property (up_m && $rose(gate_open) |-> hi_q inside {[4'h1:4'h7]})
      else $error("gate opened without recent rising edge");
   a_fall_open: assert property (dn_m && $rose(gate_open) |-> lo_q inside {[4'h1:4'h7]})
      else $error("gate opened without recent falling edge");
   a_high_open: assert property (mode_q == `TG_MODE_HIGH && $rose(gate_open) |-> hi_q != 4'h0)
      else $error("gate opened on low level");
   a_low_open: assert property (mode_q == `TG_MODE_LOW && $rose(gate_open) |-> lo_q != 4'h0)
      else $error("gate opened on high level");
   a_rise_shut: assert property ((mode_q == `TG_MODE_RISE || mode_q == `TG_MODE_HIGH) && lo_q >= 4'h7 |-> !gate_open)
      else $error("gate open while trigger low");
   a_fall_shut: assert property ((mode_q == `TG_MODE_FALL || mode_q == `TG_MODE_LOW) && hi_q >= 4'h7 |-> !gate_open)
      else $error("gate open while trigger high");
   a_done_shut: assert property ($rose(replay_done) |-> (replay_done && !gate_open)[*4])
      else $error("gate open after count reached");

   cover property ($rose(gate_open));
   cover property ($rose(replay_done));
   cover property (rd_mode_q);
endmodule : ext_gate_gen_checker

bind ext_gate_gen ext_gate_gen_checker chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .trig_main_pin(trig_main_pin), .extra_in0_pin(extra_in0_pin),
   .extra_in1_pin(extra_in1_pin), .extra_io_fitted(extra_io_fitted), .gate_open(gate_open),
   .replay_done(replay_done));

/* tb/testbench.sv */
/*
 * Self-checking bench of ext_gate_gen: register access, source mask, all gate modes, gate count.
 * Assumes one AHB-Lite master (this bench) and the trigger source model.
 */
`timescale 1ns/1ps
`include "trig_gate_map.svh"

module testbench;
   localparam logic [31:0] A_MASK = `TG_IDX_SRC_MASK * 4;
   localparam logic [31:0] A_MODE = `TG_IDX_MODE * 4;
   localparam logic [31:0] A_CTRL = `TG_IDX_CTRL * 4;
   localparam logic [31:0] A_CNT = `TG_IDX_GATE_COUNT * 4;
   localparam logic [31:0] A_STAT = `TG_IDX_STATUS * 4;
   localparam logic [31:0] A_DONE = `TG_IDX_GATES_DONE * 4;
   localparam logic [5:0][31:0] MODES = {`TG_MODE_FALL2, `TG_MODE_LOW, `TG_MODE_FALL, `TG_MODE_RISE2,
      `TG_MODE_HIGH, `TG_MODE_RISE};
   // gate after start and after each of four toggles, step 0 in bit 4
   localparam logic [5:0][4:0] GEXP = {5'h06, 5'h15, 5'h05, 5'h06, 5'h15, 5'h05};
   localparam logic [5:0][1:0] GDONE = {2'h1, 2'h2, 2'h1, 2'h1, 2'h2, 2'h1};
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic fitted = 1'b1;
   logic underrun = 1'b0;
   logic [31:0] hrdata, rv;
   logic hreadyout, hresp, gate_open, replay_done, main_pin, x0_pin, x1_pin;
   int n_errors = 0;
   int n_checks = 0;

   always #5 hclk = ~hclk;

   ext_gate_gen DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .trig_main_pin(main_pin), .extra_in0_pin(x0_pin),
      .extra_in1_pin(x1_pin), .extra_io_fitted(fitted), .replay_underrun(underrun),
      .gate_open(gate_open), .replay_done(replay_done));
   trig_src_model src (.main_pin(main_pin), .x0_pin(x0_pin), .x1_pin(x1_pin));

   // ***************************************************************
   // reporting and bus tasks
   // ***************************************************************
   task give_verdict;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : give_verdict

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task edge_rdy;
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 20);
      if (hreadyout !== 1'b1) begin
         n_errors++;
         give_verdict();
      end
   endtask : edge_rdy

   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      edge_rdy();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      edge_rdy();
      rv = hrdata;
   endtask : bus

   task wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task rdc(input logic [31:0] a, input logic [31:0] exp, input string nm);
      bus(1'b0, a, 32'h0000_0000);
      chk(nm, exp, rv);
   endtask : rdc

   // let the trigger pass synchroniser and gate logic
   task gate_is(input logic exp, input string nm);
      repeat (8) @(posedge hclk);
      chk(nm, {31'h0, exp}, {31'h0, gate_open});
   endtask : gate_is

   initial begin
      repeat (20000) @(posedge hclk);
      n_errors++;
      give_verdict();
   end

   // ***************************************************************
   // tests
   // ***************************************************************
   initial begin
      logic lv;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdc(A_MASK, 32'h0000_0000, "mask reset");
      rdc(A_MODE, 32'h0000_0000, "mode reset");
      rdc(A_CNT, 32'h0000_0000, "count reset");
      rdc(A_STAT, 32'h0000_0010, "status fitted");
      rdc(32'h0000_0100, 32'h0000_0000, "unmapped read");
      rdc(A_CTRL, 32'h0000_0000, "ctrl reads zero");
      $display("test reset done");
      wr(A_MODE, `TG_MODE_HIGH);
      wr(A_CTRL, 32'h0000_0001);
      src.put(0, 1'b1);
      gate_is(1'b0, "no source enabled");
      wr(A_MASK, 32'h0000_0100);
      rdc(A_MASK, 32'h0000_0100, "mask x0");
      gate_is(1'b0, "main masked");
      src.put(1, 1'b1);
      gate_is(1'b1, "x0 gate");
      src.put(1, 1'b0);
      fitted <= 1'b0;
      wr(A_MASK, 32'h0000_0200);
      src.put(2, 1'b1);
      gate_is(1'b0, "x1 not fitted");
      fitted <= 1'b1;
      gate_is(1'b1, "x1 gate");
      wr(A_MASK, 32'h0000_0002);
      src.put(2, 1'b0);
      gate_is(1'b1, "main gate");
      underrun <= 1'b1;
      @(posedge hclk);
      underrun <= 1'b0;
      gate_is(1'b0, "underrun close");
      rdc(A_DONE, 32'h0000_0001, "underrun uncounted");
      $display("test mask done");
      for (int i = 0; i < 6; i++) begin
         wr(A_CTRL, 32'h0000_0002);
         wr(A_MODE, MODES[i]);
         rdc(A_MODE, MODES[i], "mode readback");
         lv = (i < 3);
         src.put(0, lv);
         repeat (8) @(posedge hclk);
         wr(A_CTRL, 32'h0000_0001);
         for (int s = 0; s < 5; s++) begin
            src.put(0, lv ^ s[0]);
            gate_is(GEXP[i][4 - s], "gate step");
         end
         rdc(A_DONE, {30'h0, GDONE[i]}, "gates done");
         $display("test mode %0d done", i);
      end
      wr(A_CTRL, 32'h0000_0002);
      wr(A_MODE, `TG_MODE_RISE);
      wr(A_CNT, 32'h0000_0002);
      rdc(A_CNT, 32'h0000_0002, "count readback");
      src.put(0, 1'b0);
      wr(A_CTRL, 32'h0000_0001);
      for (int p = 0; p < 3; p++) begin
         src.put(0, 1'b1);
         gate_is(p < 2, "limited gate");
         src.put(0, 1'b0);
         gate_is(1'b0, "gate shut");
      end
      chk("done flag", 32'h0000_0001, {31'h0, replay_done});
      rdc(A_DONE, 32'h0000_0002, "gates at limit");
      rdc(A_STAT, 32'h0000_0014, "status done");
      $display("test count done");
      give_verdict();
   end
endmodule : testbench

/* tb/trig_src_model.sv */
/*
 * Model of the external TTL trigger source: main trigger and two extra inputs.
 * Assumes put is called just after a rising hclk edge; pins are plain push-pull levels.
 */
`timescale 1ns/1ps

module trig_src_model (
   output logic main_pin,
   output logic x0_pin,
   output logic x1_pin
);
   initial begin
      main_pin = 1'b0;
      x0_pin = 1'b0;
      x1_pin = 1'b0;
   end

   // level holds until the next call
   task put(input int sel, input logic v);
      case (sel)
         0: main_pin <= v;
         1: x0_pin <= v;
         default: x1_pin <= v;
      endcase
   endtask : put
endmodule : trig_src_model
